/* rtl/tud_datapath.v */
// track un-roll datapath: capture, parity, un-roll, demux, shuffle, fifo
//
// Summary of operation
// R1: take 36 track streams at 8 MHz as four groups of eight plus system.
// R2: each delay center feeds two FFT pipelines.
// R3: center 0 tracks 0-7, center 1 8-15, center 2 16-23, center 3 24-31.
// R4: parity checked across 8 or 16 tracks against the system track.
// R5: invert a marked bad track bit on each parity error.
// R6: count parity errors per center in hardware counters.
// R7: substitute the system track for a marked bad track.
// R8: roll phase zero passes all eight streams straight through.
// R9: nonzero phases undo the recorder rotation; phase 1 routes input 7 to 0.
// R10: roll steps of 1, 2 or 4 tracks, groups of 8 or 16.
// R11: 16-track groups swap paired centers' sets at phases 8-15.
// R12: roll phase advances at every frame boundary.
// R13: roll-zero indicator sampled at frame start resynchronises the phase.
// R14: output FFT cycle is 516 ticks at 32 MHz, 512 data then 4 gap.
// R15: device applies its own vernier delay in 1-to-4 and 1-to-2 modes.
// R16: host gives zero delay parameters in one-stream modes.
// R17: 2-to-1 and 4-to-1 modes de-multiplex each track into streams; code uses only tracks 0-3 or 0-1 of each center.
// R18: four shufflers make 16 MHz streams, buffer pairs merge to 32 MHz; code has a single buffer drained on 32 MHz ticks.
// R19: host loads matching shuffler personality and control words.
// R20: each shuffler holds a 32-bit control word of mux selects.
// R21: all tracks of a group plus system track captured on one edge.
`timescale 1ns/1ps
`default_nettype none
`include "tud_map.vh"

module tud_fifo #(
  parameter W  = `TUD_FIFO_W,
  parameter D  = `TUD_FIFO_D,
  parameter AW = `TUD_FIFO_AW
) (
  // clock and reset
  input  wire         sys_clk,
  input  wire         rstn,
  // fill side
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  // drain side
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  reg  [W-1:0] mem [0:D-1];
  reg  [AW-1:0] wp_q, rp_q;
  reg  [AW:0]   cnt_q;
  wire          push, pop;

  // full and empty come straight from the occupancy count
  assign in_ready  = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage has no reset, pointers do
  always @(posedge sys_clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // tud_fifo

module tud_datapath (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rstn,
  // track recovery card pins
  input  wire [31:0] trk_pin,
  input  wire [3:0]  sys_pin,
  input  wire        bit_stb_pin,
  input  wire        frame_pin,
  input  wire        roll_zero_indicator,
  // configuration
  input  wire [1:0]  roll_step,
  input  wire        roll16,
  input  wire        par16,
  input  wire [11:0] bad_trk,
  input  wire [3:0]  bad_en,
  input  wire        inv_en,
  input  wire        sub_en,
  input  wire [2:0]  btm_mode,
  // shuffler control word load
  input  wire        shuf_shift,
  input  wire [3:0]  shuf_sdi,
  // output stream toward fft pipelines
  output reg  [15:0] ffo_data,
  output reg         ffo_valid,
  input  wire        ffo_ready,
  output reg         fft_start,
  output reg         fft_gap,
  // status
  output wire        fifo_in_ready,
  output wire [63:0] perr_cnt,
  output wire [3:0]  roll_phase
);
  // rotate a group of eight by sh: out[i] = in[(i - sh) mod 8]
  function [7:0] rot8;
    input [7:0] v;
    input [2:0] sh;
    integer i;
    reg [2:0] k;
    begin
      rot8 = 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        k = i[2:0] - sh;
        rot8[i] = v[k];
      end
    end
  endfunction

  // two-stage synchronisers on every pin input
  reg  [38:0] s1_q, s2_q;
  reg         stb_d_q, frm_d_q;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q    <= 39'h0;
      s2_q    <= 39'h0;
      stb_d_q <= 1'b0;
      frm_d_q <= 1'b0;
    end else begin
      s1_q    <= {roll_zero_indicator, frame_pin, bit_stb_pin, sys_pin,
                  trk_pin};
      s2_q    <= s1_q;
      stb_d_q <= s2_q[36];
      frm_d_q <= s2_q[37];
    end
  end
  wire stb_p  = s2_q[36] && !stb_d_q;
  wire frm_p  = s2_q[37] && !frm_d_q;
  wire rz_lvl = s2_q[38];

  // capture of all groups and system tracks on one edge
  reg  [35:0] cap_q;
  reg  [4:0]  pipe_q;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cap_q  <= 36'h0;
      pipe_q <= 5'h0;
    end else begin
      if (stb_p) cap_q <= s2_q[35:0]; // R1 R3 R21
      pipe_q <= {pipe_q[3:0], stb_p};
    end
  end

  // parity check and per-track correction
  reg  [31:0] cor_d, cor_q;
  reg  [3:0]  perr;
  reg  [15:0] cnt_q [0:3];
  integer c, t, cn, cr, cd, td, cl, cs, cw, m; // one index set per process
  always @* begin
    cor_d = cap_q[31:0];
    for (c = 0; c < 4; c = c + 1) begin
      perr[c] = par16 ? // R4
        (^cap_q[(c & 2)*8 +: 16]) ^ cap_q[32 + (c & 2)] :
        (^cap_q[c*8 +: 8]) ^ cap_q[32 + c];
      for (t = 0; t < 8; t = t + 1) begin
        if (bad_en[c] && bad_trk[c*3 +: 3] == t[2:0]) begin
          if (sub_en) cor_d[c*8 + t] = cap_q[32 + c]; // R7
          else if (inv_en && perr[c])
            cor_d[c*8 + t] = ~cap_q[c*8 + t]; // R5
        end
      end
    end
  end

  // error counters run even when correction is off
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cor_q <= 32'h0;
      for (cn = 0; cn < 4; cn = cn + 1) cnt_q[cn] <= `TUD_CNT_ZERO;
    end else if (pipe_q[0]) begin
      cor_q <= cor_d;
      for (cn = 0; cn < 4; cn = cn + 1)
        if (perr[cn]) cnt_q[cn] <= cnt_q[cn] + 1'b1; // R6
    end
  end
  assign perr_cnt = {cnt_q[3], cnt_q[2], cnt_q[1], cnt_q[0]};

  // roll phase, stepped per frame, forced to zero by the indicator
  reg  [3:0] ph_q;
  wire [3:0] ph_step = 4'h1 << roll_step; // R10
  wire [3:0] ph_nxt  = ph_q + ph_step;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ph_q <= `TUD_PH_ZERO;
    end else if (frm_p) begin
      if (rz_lvl) ph_q <= `TUD_PH_ZERO; // R13
      else if (roll16) ph_q <= ph_nxt; // R12
      else ph_q <= ph_nxt & `TUD_PH8_MASK;
    end
  end
  assign roll_phase = ph_q;

  // un-roll within eight, then pair swap in sixteen-track groups
  reg  [31:0] rot_w, unr_q;
  always @* begin
    for (cr = 0; cr < 4; cr = cr + 1)
      rot_w[cr*8 +: 8] = rot8(cor_q[cr*8 +: 8], ph_q[2:0]); // R8 R9
  end
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      unr_q <= 32'h0;
    end else if (pipe_q[1]) begin
      if (roll16 && ph_q[3])
        unr_q <= {rot_w[23:16], rot_w[31:24], rot_w[7:0], rot_w[15:8]}; // R11
      else
        unr_q <= rot_w;
    end
  end

  // vernier delay line and demux phase
  reg  [31:0] dl_q [0:3];
  reg  [1:0]  dm_q;
  reg  [31:0] dmx_q, dmx_d;
  reg  [1:0]  tap;
  always @* begin
    case (btm_mode)
      `TUD_MODE_14: tap = `TUD_VERN_14; // R15
      `TUD_MODE_12: tap = `TUD_VERN_12; // R15
      default:      tap = `TUD_VERN_0;
    endcase
    dmx_d = dl_q[tap];
    for (cd = 0; cd < 4; cd = cd + 1) begin
      for (td = 0; td < 8; td = td + 1) begin
        // streams spread from low tracks, each slot holds its own phase
        if (btm_mode == `TUD_MODE_21) begin
          dmx_d[cd*8 + td] = (dm_q[0] == td[0]) ?
            unr_q[cd*8 + td/2] : dmx_q[cd*8 + td]; // R17
        end else if (btm_mode == `TUD_MODE_41) begin
          dmx_d[cd*8 + td] = (dm_q == td[1:0]) ?
            unr_q[cd*8 + td/4] : dmx_q[cd*8 + td]; // R17
        end
      end
    end
  end
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (cl = 0; cl < 4; cl = cl + 1) dl_q[cl] <= 32'h0;
      dm_q  <= 2'h0;
      dmx_q <= 32'h0;
    end else if (pipe_q[2]) begin
      dl_q[0] <= unr_q;
      for (cl = 1; cl < 4; cl = cl + 1) dl_q[cl] <= dl_q[cl-1];
      dm_q  <= dm_q + 1'b1;
      dmx_q <= dmx_d;
    end
  end

  // shuffler control words, shifted in msb first per center
  reg  [31:0] sw_q [0:3];
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (cs = 0; cs < 4; cs = cs + 1) sw_q[cs] <= 32'h0;
    end else if (shuf_shift) begin
      for (cs = 0; cs < 4; cs = cs + 1)
        sw_q[cs] <= {sw_q[cs][30:0], shuf_sdi[cs]}; // R19 R20
    end
  end

  // two shuffler writes per 8 MHz cell make the 16 MHz streams
  reg  [15:0] shf_w;
  reg  [2:0]  sel;
  wire        tg = pipe_q[4];
  wire        push = pipe_q[3] || pipe_q[4];
  always @* begin
    shf_w = 16'h0;
    sel   = 3'h0;
    for (cw = 0; cw < 4; cw = cw + 1) begin
      for (m = 0; m < 4; m = m + 1) begin
        sel = sw_q[cw][m*3 +: 3];
        if (tg && sw_q[cw][`TUD_TOG1_BIT]) sel = sel + 3'h1;
        if (tg && sw_q[cw][`TUD_TOG2_BIT]) sel = sel + 3'h2;
        shf_w[cw*4 + m] = dmx_q[cw*8 + sel]; // R2 R18 R20
      end
    end
  end

  // buffer between shufflers and the 32 MHz output pacing
  wire [15:0] fo_data;
  wire        fo_valid;
  wire        fo_pop;
  tud_fifo #(
    .W  (`TUD_FIFO_W),
    .D  (`TUD_FIFO_D),
    .AW (`TUD_FIFO_AW)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_data   (shf_w),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .out_data  (fo_data),
    .out_valid (fo_valid),
    .out_ready (fo_pop)
  );

  // 32 MHz tick from 125 MHz by phase accumulation; jitter of one clock
  reg  [7:0] acc_q;
  reg  [9:0] fc_q;
  wire [8:0] acc_s = {1'b0, acc_q} + {1'b0, `TUD_OUT_MHZ};
  wire       tick = (acc_s >= {1'b0, `TUD_CLK_MHZ});
  wire       in_gap = (fc_q >= `TUD_FFT_PTS);
  assign fo_pop = tick && !in_gap && ffo_ready && fo_valid;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      acc_q     <= 8'h00;
      fc_q      <= 10'h000;
      ffo_data  <= 16'h0000;
      ffo_valid <= 1'b0;
      fft_start <= 1'b0;
      fft_gap   <= 1'b0;
    end else begin
      acc_q     <= tick ? acc_s[7:0] - `TUD_CLK_MHZ : acc_s[7:0];
      ffo_valid <= fo_pop;
      fft_start <= tick && (fc_q == 10'h000);
      fft_gap   <= in_gap;
      if (fo_pop) ffo_data <= fo_data;
      if (tick) fc_q <= (fc_q == `TUD_FFT_MAX) ? 10'h000 : fc_q + 1'b1; // R14
    end
  end
endmodule // tud_datapath
`default_nettype wire

/* rtl/tud_map.vh */
// constants for the track un-roll datapath
`ifndef TUD_MAP_VH
`define TUD_MAP_VH
`define TUD_NCTR       4
`define TUD_NTRK       8
`define TUD_WORD_W     32
`define TUD_PH_W       4
`define TUD_PH8_MASK   4'h7
`define TUD_PH_ZERO    4'h0
`define TUD_CNT_W      16
`define TUD_CNT_ZERO   16'h0000
`define TUD_VERN_14    2'h3
`define TUD_VERN_12    2'h1
`define TUD_VERN_0     2'h0
`define TUD_MODE_14    3'h0
`define TUD_MODE_12    3'h1
`define TUD_MODE_11    3'h2
`define TUD_MODE_21    3'h3
`define TUD_MODE_41    3'h4
`define TUD_TOG1_BIT   24
`define TUD_TOG2_BIT   25
`define TUD_FIFO_W     16
`define TUD_FIFO_D     16
`define TUD_FIFO_AW    4
`define TUD_FFT_PTS    10'h200
`define TUD_FFT_CLKS   10'h204
`define TUD_FFT_MAX    10'h203
`define TUD_CLK_MHZ    8'h7d
`define TUD_OUT_MHZ    8'h20
`endif

/* verif/tb.sv */
// bench for the track un-roll datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
  // inputs, all given at time zero
  logic        sys_clk = 1'b0, rstn = 1'b0, frm_go = 1'b0, rz_go = 1'b0;
  logic        roll16 = 1'b0, par16 = 1'b0, inv_en = 1'b0, sub_en = 1'b0;
  logic        shuf_shift = 1'b0, ffo_ready = 1'b1;
  logic [35:0] pat = 36'h0;
  logic [11:0] bad_trk = 12'h000;
  logic [3:0]  bad_en = 4'h0, shuf_sdi = 4'h0;
  logic [2:0]  btm_mode = 3'h2;
  logic [1:0]  roll_step = 2'h0;
  // card pins and outputs
  logic [31:0] trk_pin;
  logic [15:0] ffo_data;
  logic [63:0] perr_cnt;
  logic [3:0]  sys_pin, roll_phase;
  logic        bit_stb_pin, frame_pin, roll_zero_indicator;
  logic        ffo_valid, fft_start, fft_gap, fifo_in_ready;
  int          n_errors = 0, tests_run = 0;
  tud_trc tud_trc_i (.*);
  tud_datapath tud_datapath_i (.*);
  initial forever #4 sys_clk = ~sys_clk;
  task automatic chk(input logic [63:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // flag ahead of the frame edge, then let phase and data settle
  task automatic frame(input logic rz);
    rz_go = rz;
    tick(8);
    frm_go = 1'b1;
    tick(8);
    frm_go = 1'b0;
    tick(320);
  endtask
  // settle a pattern, then check the word and the error growth
  task automatic run(input logic [35:0] p, input logic [5:0] cfg,
                     input logic [15:0] d, inc);
    logic [63:0] a;
    pat = p;
    {bad_en, inv_en, sub_en} = cfg;
    tick(320);
    a = perr_cnt;
    tick(160);
    chk(64'(ffo_data), 64'(d));
    if (inc != 16'hffff) chk(perr_cnt - a, {4{inc}});
  endtask
  task automatic conclude;
    $display("%0d errors in %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // long enough for every test with a wide margin
  initial begin
    #400000;
    n_errors++;
    conclude();
  end
  initial begin
    tick(16);
    chk(perr_cnt, 64'h0);
    chk(64'(roll_phase), 64'h0);
    chk(64'(fifo_in_ready), 64'h1);
    rstn = 1'b1;
    // zero control words: every mux takes its first input
    repeat (32) begin
      shuf_shift = 1'b1;
      tick(1);
      shuf_shift = 1'b0;
      tick(1);
    end
    $display("reset test done");
    run(36'hf_ffff_ffff, 6'h00, 16'hffff, 16'h000a);
    run(36'h0_ffff_ffff, 6'h00, 16'hffff, 16'h0000);
    run(36'hf_ffff_ffff, 6'h06, 16'hfff0, 16'h000a);
    run(36'h0_ffff_ffff, 6'h13, 16'hf0ff, 16'hffff);
    // sixteen-track parity: paired centers share the even system bit
    par16 = 1'b1;
    run(36'h5_00ff_00ff, 6'h00, 16'h0f0f, 16'h000a);
    par16 = 1'b0;
    for (int m = 0; m < 5; m++) begin
      btm_mode = m[2:0];
      run(36'hf_ffff_ffff, 6'h00, 16'hffff, 16'h000a);
    end
    $display("parity test done");
    btm_mode = 3'h2;
    pat = 36'hf_8080_8080;
    frame(1'b1);
    chk(64'(ffo_data), 64'h0);
    for (int s = 0; s < 3; s++) begin
      roll_step = s[1:0];
      frame(1'b0);
      chk(64'(roll_phase), (64'h1 << (s + 1)) - 64'h1);
      if (s == 0) chk(64'(ffo_data), 64'hffff);
    end
    frame(1'b1);
    chk(64'(roll_phase), 64'h0);
    roll16 = 1'b1;
    pat = 36'h0_0000_ff00;
    frame(1'b0);
    frame(1'b0);
    chk(64'(roll_phase), 64'h8);
    chk(64'(ffo_data), 64'h000f);
    $display("roll test done");
    ffo_ready = 1'b0;
    tick(400);
    chk(64'(fifo_in_ready), 64'h0);
    ffo_ready = 1'b1;
    tick(400);
    chk(64'(fifo_in_ready), 64'h1);
    $display("buffer test done");
    conclude();
  end
endmodule // tb
`default_nettype wire

/* verif/tud_datapath_properties.sv */
// checker on the track un-roll datapath ports
`timescale 1ns/1ps
`default_nettype none
module tud_chk (
  // clock, reset and inputs
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        roll_zero_indicator,
  input wire logic [1:0]  roll_step,
  input wire logic        ffo_ready,
  // outputs
  input wire logic        ffo_valid,
  input wire logic        fft_start,
  input wire logic        fft_gap,
  input wire logic [63:0] perr_cnt,
  input wire logic [3:0]  roll_phase
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [11:0] per_q;
  logic [4:0]  gap_q;
  logic        seen_q;
  // clocks since last start and in gap; first start has no period yet
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      per_q  <= 12'h000;
      gap_q  <= 5'h00;
      seen_q <= 1'b0;
    end else begin
      per_q  <= fft_start ? 12'h000 : per_q + 12'h001;
      gap_q  <= fft_gap ? gap_q + 5'h01 : 5'h00;
      seen_q <= seen_q | fft_start;
    end
  end
  a_valid_pulse: assert property (
    ffo_valid |=> !ffo_valid) else $error("valid too long");
  a_ready_stall: assert property (
    !ffo_ready ##1 !ffo_ready |-> !ffo_valid) else $error("pop in stall");
  a_start_pulse: assert property (
    fft_start |-> !fft_gap ##1 !fft_start) else $error("bad start");
  // four ticks at 32 MHz span 15 or 16 clocks
  a_gap_len: assert property (
    $fell(fft_gap) |-> gap_q inside {[15:16]}) else $error("gap length");
  a_fft_period: assert property (
    fft_start && seen_q |-> per_q inside {[2014:2015]})
    else $error("fft period");
  a_perr_step: assert property (
    $changed(perr_cnt[15:0])
    |-> perr_cnt[15:0] == $past(perr_cnt[15:0]) + 16'h1)
    else $error("count step");
  a_phase_step: assert property (
    $changed(roll_phase) && !roll_zero_indicator
    |-> roll_phase[2:0] - $past(roll_phase[2:0]) == 3'h1 << roll_step)
    else $error("phase step");
  a_phase_zero: assert property (
    $changed(roll_phase) && roll_zero_indicator |-> roll_phase == 4'h0)
    else $error("phase not zero");
endmodule // tud_chk
bind tud_datapath tud_chk tud_chk_i (.*);
`default_nettype wire

/* verif/tud_trc_model.sv */
// card model: strobed track streams, frame marks, roll-zero flag
`timescale 1ns/1ps
`default_nettype none
module tud_trc (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // bench requests
  input  wire logic [35:0] pat,
  input  wire logic        frm_go,
  input  wire logic        rz_go,
  // card pins
  output var  logic [31:0] trk_pin,
  output var  logic [3:0]  sys_pin,
  output var  logic        bit_stb_pin,
  output var  logic        frame_pin,
  output var  logic        roll_zero_indicator
);
  logic [3:0] cyc_q;
  // 16-clock cell, near 8 MHz; data moves only while strobe is low
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cyc_q               <= 4'h0;
      {sys_pin, trk_pin}  <= 36'h0;
      bit_stb_pin         <= 1'b0;
      frame_pin           <= 1'b0;
      roll_zero_indicator <= 1'b0;
    end else begin
      cyc_q       <= cyc_q + 4'h1;
      bit_stb_pin <= cyc_q < 4'h8;
      if (cyc_q == 4'h8) {sys_pin, trk_pin} <= pat;
      // flag leads the frame edge so it has settled when sampled
      roll_zero_indicator <= rz_go;
      frame_pin           <= frm_go;
    end
  end
endmodule // tud_trc
`default_nettype wire
